// ### rtl/bni_nvmem.sv
/*
  Boot memory interface: strap sampling, automatic configuration preload,
  host word reads and byte writes over serial two-wire or byte-wide memory,
  and the alternate pin roles (mailbox, fifo flags, bus-master controls)
  used when serial memory is selected.
  Assumes pin levels are resolved outside from the enables, and that the
  mailbox load clock only toggles while serial memory is selected.
*/
`timescale 1ns/100ps
`default_nettype none
module bni_nvmem
(
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  MBOX_LOAD_CLK,
  input  wire bni_pkg::bni_req_t     REQ,
  input  wire logic                  REQ_VALID,
  output logic                       REQ_READY,
  output var  logic [31:0]           RESP_DATA,
  output var  logic                  RESP_ERR,
  output var  logic                  RESP_VALID,
  output var  bni_pkg::bni_preload_t PRELOAD,
  output var  logic                  PRELOAD_DONE,
  output var  logic                  MEM_SERIAL,
  output var  logic                  NO_MEM,
  output var  logic [7:0]            MBOX_DATA,
  output var  logic                  MBOX_VALID,
  output var  logic [3:0]            BM_CTRL,
  input  wire logic                  HOST_TO_ADDON_FIFO_FULL_N,
  input  wire logic                  ADDON_TO_HOST_FIFO_EMPTY_N,
  input  wire logic                  SERIAL_MEM_SELECT_STRAP,
  input  wire logic                  PIN_FLOAT_CONTROL_N,
  output logic                       SCL_EXT_MEM_READ_STROBE_N,
  input  wire logic                  SDA_EXT_MEM_WRITE_STROBE_N_I,
  output logic                       SDA_EXT_MEM_WRITE_STROBE_N_O,
  output logic                       SDA_EXT_MEM_WRITE_STROBE_N_OE,
  input  wire logic [7:0]            EXT_MEM_ADDRESS_LOW_I,
  output logic [15:0]                EXT_MEM_ADDRESS_O,
  output logic [15:0]                EXT_MEM_ADDRESS_OE,
  input  wire logic [7:0]            EXT_MEM_DATA_BUS_I,
  output logic [7:0]                 EXT_MEM_DATA_BUS_O,
  output logic [7:0]                 EXT_MEM_DATA_BUS_OE
);
  import bni_pkg::*;

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  bni_state_t  state;
  bni_req_t    acc;
  bni_req_t    launch_req;
  bni_op_t     op;
  logic        strap_s1, strap_s2, flt_s1, flt_s2, sda_s1, sda_s2;
  logic [7:0]  eq_s1, eq_s2;
  logic        preloading, err, scl_drv, sda_rel, erd_n, ewr_n;
  logic [3:0]  pl_idx, step, bit_k;
  logic [1:0]  byte_k, qtr;
  logic [7:0]  timer, shreg;
  logic [15:0] ext_addr;
  logic [31:0] word_buf;
  logic [1:0]  fifo_flags;
  logic [2:0]  rd_rises;
  logic        lrst1, lrst2, mbox_tgl;
  logic [7:0]  mbox_link;
  logic        tg1, tg2, tg3;
  wire  logic  launch_pre, launch_host, launch, launch_serial, strap_done;
  wire  logic [3:0]  pl_next_idx, ser_last, next_step, rx_off;
  wire  logic [15:0] pl_addr;
  wire  logic  bit_high, op_is_bit, quarter_end, sample_now, bit_end, op_end;
  wire  logic  ser_scl, ser_sda_rel, strobe_end, bw_active, mbox_evt;
  wire  logic [7:0]  rx_shift;

  // picks the byte sent on the serial bus for a given framing step
  function automatic logic [7:0] tx_byte(input logic [3:0] s, input bni_req_t r);
    logic [7:0] b;
    b = r.wdata;
    if (s == SER_DEV_STEP)
      b = {SER_DEV_ADDR, SER_DIR_WRITE};
    else if (s == SER_AHI_STEP)
      b = 8'(r.addr >> 8);
    else if (s == SER_ALO_STEP)
      b = 8'(r.addr);
    else if (s == SER_DEVR_STEP && !r.we)
      b = {SER_DEV_ADDR, SER_DIR_READ};
    return b;
  endfunction

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  // the strap, float, serial data and data bus pins pass two flops before the control logic looks at them
  always_ff @(posedge CLK)
  begin
    strap_s1 <= SERIAL_MEM_SELECT_STRAP;
    strap_s2 <= strap_s1;
    flt_s1   <= PIN_FLOAT_CONTROL_N;
    flt_s2   <= flt_s1;
    sda_s1   <= SDA_EXT_MEM_WRITE_STROBE_N_I;
    sda_s2   <= sda_s1;
    eq_s1    <= EXT_MEM_DATA_BUS_I;
    eq_s2    <= eq_s1;
  end

  // ----------------------------------------------------------------------------
  // access launch and serial decode
  // ----------------------------------------------------------------------------
  // preload has priority; host requests wait until it is over
  assign strap_done    = (state == ST_STRAP) && (timer == 8'h00);
  assign launch_pre    = strap_done || ((state == ST_FINISH) && preloading && !err &&
                         (pl_idx != PRELOAD_LAST_IDX));                      // see RULE16
  assign launch_host   = (state == ST_IDLE) && REQ_VALID;
  assign launch        = launch_pre || launch_host;
  assign launch_serial = (state == ST_STRAP) ? strap_s2 : MEM_SERIAL;         // see RULE4
  assign pl_next_idx   = (state == ST_STRAP) ? 4'h0 : (pl_idx + 4'h1);
  assign pl_addr       = PRELOAD_FIRST + (16'(pl_next_idx) << WORD_SHIFT);     // see RULE7
  assign launch_req    = launch_pre ? bni_req_t'{we: 1'b0, addr: pl_addr, wdata: 8'h00} : REQ;
  assign REQ_READY     = (state == ST_IDLE);                                  // see RULE16

  // framing: start, device, address, data or restart, device, four bytes, stop
  assign ser_last  = acc.we ? SER_LAST_WRITE : SER_LAST_READ;
  assign op        = ((step == SER_START_STEP) || (!acc.we && step == SER_RESTART_STEP)) ? OP_START
                   : (step == ser_last) ? OP_STOP
                   : (!acc.we && step >= SER_FIRST_RX) ? OP_RX : OP_TX;       // see RULE17
  assign op_is_bit = (op == OP_TX) || (op == OP_RX);
  assign bit_high  = (qtr == QTR_RISE) || (qtr == QTR_SAMPLE);
  assign ser_scl   = (op == OP_STOP) ? (qtr != QTR_FIRST) : bit_high;
  // data moves only with the clock low, except the start and stop edges
  assign ser_sda_rel = (op == OP_START) ? (qtr < QTR_SAMPLE)
                     : (op == OP_STOP)  ? (qtr >= QTR_SAMPLE)
                     : (bit_k == ACK_BIT) ? ((op == OP_TX) || (step == SER_LAST_RX))
                     : (op == OP_TX) ? shreg[BYTE_MSB] : 1'b1;              // see RULE17
  assign quarter_end = (state == ST_SER) && (timer == 8'h00);
  assign sample_now  = quarter_end && (qtr == QTR_SAMPLE);
  assign bit_end     = quarter_end && (qtr == QTR_LAST) && op_is_bit && (bit_k != ACK_BIT);
  assign op_end      = quarter_end && (qtr == QTR_LAST) && !(op_is_bit && (bit_k != ACK_BIT));
  assign next_step   = err ? ser_last : (step + 4'h1);
  assign rx_off      = step - SER_FIRST_RX;
  assign rx_shift    = {shreg[BYTE_MSB-1:0], sda_s2};                         // see RULE3
  assign strobe_end  = (state == ST_BW_STROBE) && (timer == 8'h00);
  assign bw_active   = (state == ST_BW_SETUP) || (state == ST_BW_STROBE) || (state == ST_BW_HOLD);

  // ----------------------------------------------------------------------------
  // pin muxing
  // ----------------------------------------------------------------------------
  // shared pins follow the memory type; float only touches byte-wide roles
  assign SCL_EXT_MEM_READ_STROBE_N     = MEM_SERIAL ? scl_drv : erd_n;         // see RULE1, see RULE2
  assign SDA_EXT_MEM_WRITE_STROBE_N_O  = MEM_SERIAL ? 1'b0 : ewr_n;            // see RULE3
  assign SDA_EXT_MEM_WRITE_STROBE_N_OE = MEM_SERIAL ? !sda_rel : flt_s2;       // see RULE5
  assign EXT_MEM_ADDRESS_O  = MEM_SERIAL ? {fifo_flags, 14'h0000} : ext_addr;   // see RULE8, see RULE10
  assign EXT_MEM_ADDRESS_OE = MEM_SERIAL ? {2'b11, 14'h0000} : {16{flt_s2}};   // see RULE9
  assign EXT_MEM_DATA_BUS_O  = acc.wdata;
  assign EXT_MEM_DATA_BUS_OE = {8{!MEM_SERIAL && flt_s2 && acc.we && bw_active}}; // see RULE11, see RULE14

  // ----------------------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= ST_STRAP; acc <= '0; timer <= STRAP_LOAD; MEM_SERIAL <= 1'b1;
      preloading <= 1'b1; PRELOAD_DONE <= 1'b0; NO_MEM <= 1'b0; pl_idx <= 4'h0;
      err <= 1'b0; step <= 4'h0; bit_k <= 4'h0; qtr <= QTR_FIRST; byte_k <= 2'h0;
      shreg <= 8'hff; ext_addr <= 16'h0000; word_buf <= 32'h0; erd_n <= 1'b1; ewr_n <= 1'b1;
      scl_drv <= 1'b1; sda_rel <= 1'b1; RESP_DATA <= 32'h0; RESP_ERR <= 1'b0;
      RESP_VALID <= 1'b0; PRELOAD <= '0; fifo_flags <= 2'b11; BM_CTRL <= 4'h0; rd_rises <= 3'h0;
    end
    else
    begin
      RESP_VALID <= 1'b0;
      PRELOAD.we <= 1'b0;
      scl_drv    <= (state == ST_SER) ? ser_scl : 1'b1;                       // see RULE1
      sda_rel    <= (state == ST_SER) ? ser_sda_rel : 1'b1;                   // see RULE3
      fifo_flags <= {HOST_TO_ADDON_FIFO_FULL_N, ADDON_TO_HOST_FIFO_EMPTY_N};  // see RULE10
      BM_CTRL    <= MEM_SERIAL ? eq_s2[BYTE_MSB -: 4] : 4'h0;                 // see RULE11
      if (strap_done)
        MEM_SERIAL <= strap_s2;                                               // see RULE4
      if (launch_pre)
        pl_idx <= pl_next_idx;
      if (strobe_end && !acc.we)
        rd_rises <= rd_rises + 3'h1;
      // hand each preloaded word on; a missing serial memory ends the preload
      if ((state == ST_FINISH) && preloading)
      begin
        PRELOAD <= '{we: !err, index: pl_idx, data: word_buf};               // see RULE7
        if (err || (pl_idx == PRELOAD_LAST_IDX))
        begin
          preloading <= 1'b0;
          PRELOAD_DONE <= 1'b1;
          NO_MEM <= err;
        end
      end
      if (launch)
      begin
        acc <= launch_req; ext_addr <= launch_req.addr; byte_k <= 2'h0; rd_rises <= 3'h0;
        step <= SER_START_STEP; bit_k <= 4'h0; qtr <= QTR_FIRST; err <= 1'b0;
        timer <= launch_serial ? QTR_LOAD : 8'h00;
        state <= launch_serial ? ST_SER : ST_BW_SETUP;
      end
      else
      begin
        unique case (state)
          ST_STRAP:
            timer <= timer - 8'h01;
          ST_IDLE:
            timer <= 8'h00;
          // address and data settle one cycle before the strobe falls
          ST_BW_SETUP:
          begin
            state <= ST_BW_STROBE;
            timer <= acc.we ? WR_LOAD : RD_LOAD;
            erd_n <= acc.we;                                                  // see RULE12
            ewr_n <= !acc.we;                                                 // see RULE14
          end
          ST_BW_STROBE:
          begin
            timer <= strobe_end ? 8'h00 : (timer - 8'h01);
            if (strobe_end)
            begin
              erd_n <= 1'b1;
              ewr_n <= 1'b1;
              state <= ST_BW_HOLD;
              if (!acc.we)
                word_buf[{byte_k, 3'h0} +: 8] <= eq_s2;                       // see RULE13
            end
          end
          // one hold cycle keeps address and data past the rising strobe
          ST_BW_HOLD:
          begin
            if (!acc.we && (byte_k != BYTE_LAST))
            begin
              byte_k   <= byte_k + 2'h1;                                      // see RULE6
              ext_addr <= ext_addr + 16'h0001;
              state    <= ST_BW_SETUP;
            end
            else
              state <= ST_FINISH;
          end
          // serial bit engine: four quarters per bit, sample in the third
          ST_SER:
          begin
            timer <= quarter_end ? QTR_LOAD : (timer - 8'h01);
            if (quarter_end)
              qtr <= qtr + 2'h1;
            if (sample_now && (op == OP_TX) && (bit_k == ACK_BIT) && sda_s2)
              err <= 1'b1;                                                    // see RULE17
            if (sample_now && (op == OP_RX) && (bit_k != ACK_BIT))
              shreg <= rx_shift;
            if (bit_end)
            begin
              bit_k <= bit_k + 4'h1;
              if (op == OP_TX)
                shreg <= shreg << 1;
            end
            if (op_end)
            begin
              bit_k <= 4'h0;
              shreg <= tx_byte(next_step, acc);
              if (op == OP_RX)
                word_buf[{rx_off[1:0], 3'h0} +: 8] <= shreg;
              if (step == ser_last)
                state <= ST_FINISH;
              else
                step <= next_step;
            end
          end
          ST_FINISH:
          begin
            state <= ST_IDLE;
            if (!preloading)
            begin
              RESP_VALID <= 1'b1;
              RESP_DATA  <= word_buf;
              RESP_ERR   <= err;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // mailbox on the link clock
  // ----------------------------------------------------------------------------
  // the mailbox byte is captured on its own load clock; a toggle carries the event over
  always_ff @(posedge MBOX_LOAD_CLK)
  begin
    lrst1 <= RST;
    lrst2 <= lrst1;
    if (lrst2)
    begin
      mbox_link <= 8'h00;
      mbox_tgl  <= 1'b0;
    end
    else
    begin
      mbox_link <= EXT_MEM_ADDRESS_LOW_I;                                      // see RULE9
      mbox_tgl  <= !mbox_tgl;
    end
  end

  // the byte is stable by the time the synchronised toggle is seen
  assign mbox_evt = tg2 ^ tg3;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      tg1 <= 1'b0; tg2 <= 1'b0; tg3 <= 1'b0; MBOX_DATA <= 8'h00; MBOX_VALID <= 1'b0;
    end
    else
    begin
      tg1 <= mbox_tgl;
      tg2 <= tg1;
      tg3 <= tg2;
      MBOX_VALID <= mbox_evt && MEM_SERIAL;
      if (mbox_evt && MEM_SERIAL)
        MBOX_DATA <= mbox_link;                                               // see RULE9
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  scl_park_a: assert property (MEM_SERIAL && (state == ST_IDLE) |-> SCL_EXT_MEM_READ_STROBE_N) // see RULE1
    else $error("serial clock not parked high while idle");
  wr_pin_a: assert property (!MEM_SERIAL && (state == ST_BW_STROBE) && acc.we |-> !SDA_EXT_MEM_WRITE_STROBE_N_O) // see RULE2
    else $error("shared pin not showing write strobe");
  sda_od_a: assert property (MEM_SERIAL |-> !SDA_EXT_MEM_WRITE_STROBE_N_O) // see RULE3
    else $error("serial data driven high");
  strap_take_a: assert property (strap_done |=> MEM_SERIAL == $past(strap_s2)) // see RULE4
    else $error("memory type not taken from strap");
  float_free_a: assert property (MEM_SERIAL && !sda_rel |-> SDA_EXT_MEM_WRITE_STROBE_N_OE) // see RULE5
    else $error("serial data released by float control");
  four_reads_a: assert property ((state == ST_FINISH) && !MEM_SERIAL && !acc.we |-> rd_rises == BYTES_PER_WORD) // see RULE6
    else $error("word not built from four byte reads");
  preload_rng_a: assert property (preloading && !MEM_SERIAL && !erd_n |->
    (ext_addr >= PRELOAD_FIRST) && (ext_addr <= PRELOAD_LAST)) // see RULE7
    else $error("preload read outside its range");
  addr_drive_a: assert property (!MEM_SERIAL && !erd_n && flt_s2 |-> &EXT_MEM_ADDRESS_OE) // see RULE8
    else $error("address not fully driven during read");
  mbox_load_a: assert property (MBOX_VALID |-> MEM_SERIAL && (MBOX_DATA == mbox_link)) // see RULE9
    else $error("mailbox loaded outside serial mode");
  fifo_flag_a: assert property (MEM_SERIAL && $past(MEM_SERIAL) && !$past(RST) |->
    EXT_MEM_ADDRESS_O == {$past(HOST_TO_ADDON_FIFO_FULL_N), $past(ADDON_TO_HOST_FIFO_EMPTY_N), 14'h0000}) // see RULE10
    else $error("fifo flags not shown on address pins");
  bm_input_a: assert property (MEM_SERIAL |-> EXT_MEM_DATA_BUS_OE == 8'h00) // see RULE11
    else $error("data pins driven in serial mode");
  rd_low_a: assert property ($fell(erd_n) |-> !erd_n [*4] ##1 erd_n) // see RULE12
    else $error("read strobe low time wrong");
  rd_capture_a: assert property ($rose(erd_n) |-> word_buf[{byte_k, 3'h0} +: 8] == $past(eq_s2)) // see RULE13
    else $error("read byte not captured on strobe rise");
  wr_stable_a: assert property (!ewr_n && $past(!ewr_n) |-> $stable(EXT_MEM_ADDRESS_O) && $stable(EXT_MEM_DATA_BUS_O)) // see RULE14
    else $error("address or data moved under write strobe");
  no_host_a: assert property (REQ_READY |-> PRELOAD_DONE) // see RULE16
    else $error("host served before preload ended");
  sda_edge_a: assert property (MEM_SERIAL && $changed(sda_rel) && scl_drv && $past(scl_drv) |->
    ($past(op) == OP_START) || ($past(op) == OP_STOP)) // see RULE17
    else $error("serial data moved while clock high");

endmodule
`default_nettype wire

// ### rtl/bni_pkg.sv
/*
  Constants, types and timing figures for the boot memory interface that
  fetches configuration preload words from serial or byte-wide memory.
  Assumes a 10 MHz system clock and a single attached boot memory.
*/
// Behaviour
// RULE1 - serial mode: this block alone masters the two-wire bus and drives its clock.
// RULE2 - serial clock shares the read strobe pin; serial data shares the write strobe pin.
// RULE3 - serial data is open drain: pulled low or released, sampled when receiving.
// RULE4 - strap high means serial or no memory; strap low means byte-wide memory.
// RULE5 - the float control input never disturbs the serial clock or data pins.
// RULE6 - a 32-bit byte-wide read is four 8-bit read cycles, one byte each.
// RULE7 - memory bytes 0040h to 007Fh preload the bus configuration registers.
// RULE8 - memory holds 128 bytes to 64K bytes; the address outputs carry 16 bits.
// RULE9 - serial mode: low eight address pins form a mailbox loaded by address pin 8.
// RULE10 - serial mode: address pin 15 shows fifo full, pin 14 shows fifo empty.
// RULE11 - serial mode: data pins 4 to 7 become bus-master control inputs.
// RULE12 - the read strobe stays low for the whole of each byte-wide read.
// RULE13 - read data is captured when the read strobe rises.
// RULE14 - write strobe low during writes; address and data stay stable meanwhile.
// RULE15 - a system attaches either serial or byte-wide boot memory, never both.
// RULE16 - preload runs by itself after reset, before host accesses are taken.
// RULE17 - serial transfers use start, stop, address byte with direction, acknowledges.
package bni_pkg;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SCL_QUARTER_NS = 2500;  // quarter of a 100 kHz serial bit
  localparam int unsigned RD_LOW_NS      = 400;   // least read strobe low time
  localparam int unsigned WR_LOW_NS      = 300;   // least write strobe low time
  localparam int unsigned QTR_CYC        = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_LOW_CYC     = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_LOW_CYC     = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  QTR_LOAD       = 8'(QTR_CYC - 1);
  localparam logic [7:0]  RD_LOAD        = 8'(RD_LOW_CYC - 1);
  localparam logic [7:0]  WR_LOAD        = 8'(WR_LOW_CYC - 1);
  localparam logic [7:0]  STRAP_LOAD     = 8'h03;  // lets the strap synchroniser settle

  // ----------------------------------------------------------------------------
  // memory map and framing
  // ----------------------------------------------------------------------------
  localparam logic [15:0] PRELOAD_FIRST    = 16'h0040;
  localparam logic [15:0] PRELOAD_LAST     = 16'h007f;
  localparam logic [3:0]  PRELOAD_LAST_IDX = 4'hf;
  localparam int unsigned WORD_SHIFT       = 2;
  localparam logic [1:0]  BYTE_LAST        = 2'h3;
  localparam logic [2:0]  BYTES_PER_WORD   = 3'h4;
  localparam int unsigned BYTE_MSB         = 7;
  localparam logic [6:0]  SER_DEV_ADDR     = 7'h50;  // memory device address on the serial bus
  localparam logic        SER_DIR_WRITE    = 1'b0;
  localparam logic        SER_DIR_READ     = 1'b1;
  localparam logic [3:0]  SER_START_STEP   = 4'h0;
  localparam logic [3:0]  SER_DEV_STEP     = 4'h1;
  localparam logic [3:0]  SER_AHI_STEP     = 4'h2;
  localparam logic [3:0]  SER_ALO_STEP     = 4'h3;
  localparam logic [3:0]  SER_RESTART_STEP = 4'h4;
  localparam logic [3:0]  SER_DEVR_STEP    = 4'h5;
  localparam logic [3:0]  SER_FIRST_RX     = 4'h6;
  localparam logic [3:0]  SER_LAST_RX      = 4'h9;
  localparam logic [3:0]  SER_LAST_READ    = 4'ha;
  localparam logic [3:0]  SER_LAST_WRITE   = 4'h5;
  localparam logic [3:0]  ACK_BIT          = 4'h8;
  localparam logic [1:0]  QTR_FIRST        = 2'h0;
  localparam logic [1:0]  QTR_RISE         = 2'h1;
  localparam logic [1:0]  QTR_SAMPLE       = 2'h2;
  localparam logic [1:0]  QTR_LAST         = 2'h3;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP     = 3'h0,
    ST_IDLE      = 3'h1,
    ST_BW_SETUP  = 3'h2,
    ST_BW_STROBE = 3'h3,
    ST_BW_HOLD   = 3'h4,
    ST_SER       = 3'h5,
    ST_FINISH    = 3'h6
  } bni_state_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_TX    = 2'h1,
    OP_RX    = 2'h2,
    OP_STOP  = 2'h3
  } bni_op_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bni_req_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  index;
    logic [31:0] data;
  } bni_preload_t;

endpackage

// ### test/bni_mem_model.sv
/* byte-wide boot memory model, 256 bytes mirrored over the 16-bit space.
   assumes strobes active low and address steady while a strobe is low. */
`timescale 1ns/100ps
`default_nettype none
module bni_mem_model
(
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  output var  logic [7:0]  RDATA
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  // contents: low address byte xor 5a; the only memory fitted, above the minimum size
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // drives only under the read strobe; stale byte inverted so a late capture shows
  always_comb RDATA = RD_N ? ~last : mem[ADDR[7:0]];
  always @(posedge RD_N) last <= mem[ADDR[7:0]];
  // byte stored as the write strobe ends
  always @(posedge WR_N) mem[ADDR[7:0]] <= WDATA;
endmodule
`default_nettype wire

// ### test/bni_nvmem_tb.sv
/* bench for the boot memory interface: byte-wide mode against a memory model, then
   serial mode with no serial memory fitted. assumes frames end on the first nack. */
`timescale 1ns/100ps
`default_nettype none
module bni_nvmem_tb;
  import bni_pkg::*;
  logic clk = 1'b0, rst = 1'b1, lclk = 1'b0, req_valid = 1'b0;
  logic strap = 1'b0, flt_n = 1'b1, ff_n = 1'b1, lrun = 1'b0;
  logic [3:0] bm = 4'h0;
  logic [7:0] mbox_in = 8'h00;
  bni_req_t req = '0;
  wire logic ready, rvalid, done, ser, nomem, rd_n, sda_o, sda_oe, rerr, mvalid;
  wire logic [31:0] rdata;
  wire bni_preload_t pl;
  wire logic [15:0] ea, eoe;
  wire logic [7:0] dq_o, dq_oe, mdat, mdata;
  wire logic [3:0] bmc;
  wire logic wr_n = sda_oe ? sda_o : 1'b1;  // pull-up on the shared pin
  // a serial system has no byte-wide memory; the add-on drives the control nibble instead
  wire logic [7:0] dq = dq_oe[0] ? dq_o : strap ? {bm, 4'h0} : mdat;
  int errors = 0, check_count = 0, cyc = 0, pl_n = 0, sda_lo = 0;
  always #50 clk = ~clk;
  // link clock runs in reset and in short bursts for a mailbox load, since loads must be spaced
  always #16 if (rst || lrun) lclk = ~lclk;
  bni_nvmem u_bni_nvmem
  (
    .CLK(clk), .RST(rst), .MBOX_LOAD_CLK(lclk), .REQ(req), .REQ_VALID(req_valid), .REQ_READY(ready),
    .RESP_DATA(rdata), .RESP_ERR(rerr), .RESP_VALID(rvalid), .PRELOAD(pl), .PRELOAD_DONE(done),
    .MEM_SERIAL(ser), .NO_MEM(nomem), .MBOX_DATA(mdata), .MBOX_VALID(mvalid), .BM_CTRL(bmc),
    .HOST_TO_ADDON_FIFO_FULL_N(ff_n), .ADDON_TO_HOST_FIFO_EMPTY_N(1'b1), .SERIAL_MEM_SELECT_STRAP(strap),
    .PIN_FLOAT_CONTROL_N(flt_n), .SCL_EXT_MEM_READ_STROBE_N(rd_n), .SDA_EXT_MEM_WRITE_STROBE_N_I(wr_n),
    .SDA_EXT_MEM_WRITE_STROBE_N_O(sda_o), .SDA_EXT_MEM_WRITE_STROBE_N_OE(sda_oe), .EXT_MEM_ADDRESS_LOW_I(mbox_in),
    .EXT_MEM_ADDRESS_O(ea), .EXT_MEM_ADDRESS_OE(eoe), .EXT_MEM_DATA_BUS_I(dq), .EXT_MEM_DATA_BUS_O(dq_o),
    .EXT_MEM_DATA_BUS_OE(dq_oe)
  );
  bni_mem_model u_bni_mem_model
  (
    .ADDR(ea), .WDATA(dq), .RD_N(rd_n | strap), .WR_N(wr_n | strap), .RDATA(mdat)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected word: four bytes from the model's fill pattern, lowest address in bits 7:0
  function automatic logic [31:0] word(input logic [15:0] a);
    return {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]} ^ 32'h5a5a5a5a;
  endfunction
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{we, a, d};
    req_valid <= 1'b1;
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (rvalid !== 1'b1) @(negedge clk);
  endtask
  // preload words, write-strobe pins and the hang limit
  always @(negedge clk)
  begin
    cyc++;
    if (pl.we === 1'b1) chk(pl.data, word(16'h0040 + {10'h0, pl.index, 2'h0}));
    if (pl.we === 1'b1) pl_n++;
    if (!rst && !ser && wr_n === 1'b0) chk({ea, dq}, {16'h0010, 8'hc3});
    if (!rst && ser && wr_n === 1'b0) sda_lo++;
    if (cyc == 6000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic t_preload;
    @(negedge clk);
    while (done !== 1'b1) @(negedge clk);
    @(negedge clk);  // the last preload pulse is counted on the same edge as done
    chk(pl_n, 16);
    chk({ser, nomem}, 2'b00);
  endtask
  // read across the mirror wrap, write one byte, read it back inside a word
  task automatic t_rw;
    access(1'b0, 16'h00fd, 8'h00);
    chk(rdata, word(16'h00fd));
    access(1'b1, 16'h0010, 8'hc3);
    access(1'b0, 16'h000f, 8'h00);
    chk(rdata, (word(16'h000f) & 32'hffff00ff) | 32'h0000c300);
  endtask
  // mid-run reset into serial mode with float low: no memory answers, so preload aborts
  task automatic t_serial;
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b1;
    flt_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ff_n <= 1'b0;
    bm <= 4'h9;
    mbox_in <= 8'ha5;
    lrun <= 1'b1;
    // two link edges release the link reset, the third loads the mailbox
    repeat (3) @(posedge lclk);
    lrun <= 1'b0;
    @(negedge clk);
    while (mvalid !== 1'b1) @(negedge clk);
    chk(mdata, 8'ha5);
    chk({bmc, ea, eoe}, {4'h9, 16'h4000, 16'hc000});
    while (done !== 1'b1) @(negedge clk);
    chk({ser, nomem, rd_n, sda_lo != 0}, 4'hf);
    chk(pl_n, 16);
    access(1'b0, 16'h0040, 8'h00);
    chk(rerr, 1'b1);
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_preload();
    t_rw();
    t_serial();
    summarize();
  end
endmodule
`default_nettype wire
